// ===== rtl/dim_pkg.sv
// constants and types shared by the channel dimming controller
package dim_pkg;
    // ==========================================================
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam int TICK_CW = 12;
    // ==========================================================
    // brightness
    localparam int BW = 8;
    localparam logic [7:0] LVL_OFF = 8'h00;
    localparam logic [7:0] LVL_FULL = 8'hff;
    localparam int PW = 24;
    localparam logic [23:0] PERIOD_ZERO = 24'h000000;
    localparam int ACC_W = 32;
    // ==========================================================
    // states
    typedef enum {DYN_IDLE, DYN_RAMP1, DYN_HOLD, DYN_RAMP2, DYN_DONE} dyn_state_t;
endpackage

// ===== rtl/ramp_gen.sv
// one ramp generator: moves a level toward a target in ticked steps
`timescale 1ns/1ps
`default_nettype none
module ramp_gen (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [7:0] load_lvl_i,
    input wire logic [7:0] target_i,
    input wire logic [23:0] period_i,
    output logic [7:0] level_o,
    output logic at_target_o
);
    logic [7:0] level_reg, level_next;
    logic [31:0] acc_reg, acc_next;
    logic [31:0] sum;

    // period_i is ticks for a full 0..255 sweep; the accumulator advances 255 per
    // tick and yields one step per period, so slow ramps need no divider
    always_comb begin
        level_next = level_reg;
        acc_next = acc_reg;
        sum = acc_reg + 32'({24'h0, dim_pkg::LVL_FULL});
        if (load_i) begin
            level_next = load_lvl_i;
            acc_next = '0;
        end else if (level_reg == target_i) begin
            acc_next = '0;
        end else if (period_i == dim_pkg::PERIOD_ZERO) begin
            level_next = target_i;
        end else if (tick_i) begin
            if (sum >= {8'h0, period_i}) begin
                acc_next = sum - {8'h0, period_i};
                level_next = (level_reg < target_i) ? level_reg + 8'h01 : level_reg - 8'h01;
            end else begin
                acc_next = sum;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_reg <= 8'h00;
            acc_reg <= 32'h0;
        end else begin
            level_reg <= level_next;
            acc_reg <= acc_next;
        end
    end

    assign level_o = level_reg;
    assign at_target_o = (level_reg == target_i);
endmodule
`default_nettype wire

// ===== rtl/dim_channel.sv
// one dimming channel: normal and dynamic modes driving a target brightness
`timescale 1ns/1ps
`default_nettype none
module dim_channel (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic dyn_mode_i,
    input wire logic burn_in_i,
    input wire logic [7:0] on_level_i,
    input wire logic [7:0] min_level_i,
    input wire logic [7:0] max_level_i,
    input wire logic dim_on_ok_i,
    input wire logic dim_off_ok_i,
    input wire logic set_turns_on_i,
    input wire logic onoff_const_i,
    input wire logic [23:0] onoff_period_i,
    input wire logic [23:0] set_period_i,
    input wire logic [23:0] rel_period_i,
    input wire logic [7:0] dyn_start_i,
    input wire logic [7:0] dyn_hold_i,
    input wire logic [7:0] dyn_off_i,
    input wire logic [23:0] dyn_ramp1_period_i,
    input wire logic [23:0] dyn_hold_ticks_i,
    input wire logic [23:0] dyn_ramp2_period_i,
    input wire logic onoff_stb_i,
    input wire logic onoff_val_i,
    input wire logic set_stb_i,
    input wire logic [7:0] set_val_i,
    input wire logic rel_stb_i,
    input wire logic rel_up_i,
    input wire logic rel_stop_i,
    output logic [7:0] level_o,
    output logic is_on_o,
    output logic dyn_busy_o
);
    // ==========================================================
    // tick divider
    logic [11:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;

    always_comb begin
        tick_next = 1'b0;
        tick_cnt_next = tick_cnt_reg + 12'h001;
        if (tick_cnt_reg == 12'(dim_pkg::TICK_CYCLES - 1)) begin
            tick_cnt_next = 12'h000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_reg <= 12'h000;
            tick_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // ==========================================================
    // effective limits
    logic [7:0] eff_min, eff_max, on_clamped, set_clamped;

    always_comb begin
        eff_min = min_level_i;
        eff_max = max_level_i;
        // one comparison covers both forcing directions: whichever is set
        // inconsistently, both collapse to the same level
        if (min_level_i > max_level_i) begin
            eff_min = max_level_i;
            eff_max = max_level_i;
        end
        on_clamped = on_level_i;
        if (on_level_i < eff_min) begin
            on_clamped = eff_min;
        end else if (on_level_i > eff_max) begin
            on_clamped = eff_max;
        end
        set_clamped = set_val_i;
        if (set_val_i < eff_min) begin
            set_clamped = eff_min;
        end else if (set_val_i > eff_max) begin
            set_clamped = eff_max;
        end
    end

    // ==========================================================
    // command state
    dim_pkg::dyn_state_t dyn_reg, dyn_next;
    logic [7:0] target_reg, target_next;
    logic [23:0] period_reg, period_next;
    logic on_reg, on_next;
    logic [23:0] hold_cnt_reg, hold_cnt_next;
    logic load;
    logic [7:0] load_lvl;
    logic [7:0] ramp_level;
    logic at_target;
    logic [23:0] onoff_rate;

    assign onoff_rate = onoff_const_i ? rel_period_i : onoff_period_i;

    always_comb begin
        dyn_next = dyn_reg;
        target_next = target_reg;
        period_next = period_reg;
        on_next = on_reg;
        hold_cnt_next = hold_cnt_reg;
        load = 1'b0;
        load_lvl = dim_pkg::LVL_OFF;
        if (dyn_mode_i) begin
            // only on/off is honoured here; limits are not applied
            unique case (dyn_reg)
                dim_pkg::DYN_IDLE, dim_pkg::DYN_DONE: begin
                    if (onoff_stb_i && onoff_val_i) begin
                        load = 1'b1;
                        load_lvl = dyn_start_i;
                        target_next = dyn_hold_i;
                        period_next = dyn_ramp1_period_i;
                        on_next = 1'b1;
                        dyn_next = dim_pkg::DYN_RAMP1;
                    end
                end
                dim_pkg::DYN_RAMP1: begin
                    if (onoff_stb_i && !onoff_val_i) begin
                        target_next = dyn_off_i;
                        period_next = dyn_ramp2_period_i;
                        dyn_next = dim_pkg::DYN_RAMP2;
                    end else if (at_target) begin
                        hold_cnt_next = 24'h000000;
                        dyn_next = dim_pkg::DYN_HOLD;
                    end
                end
                dim_pkg::DYN_HOLD: begin
                    if (onoff_stb_i && !onoff_val_i) begin
                        target_next = dyn_off_i;
                        period_next = dyn_ramp2_period_i;
                        dyn_next = dim_pkg::DYN_RAMP2;
                    end else if (onoff_stb_i) begin
                        hold_cnt_next = 24'h000000;
                    end else if (hold_cnt_reg >= dyn_hold_ticks_i) begin
                        target_next = dyn_off_i;
                        period_next = dyn_ramp2_period_i;
                        dyn_next = dim_pkg::DYN_RAMP2;
                    end else if (tick_reg) begin
                        hold_cnt_next = hold_cnt_reg + 24'h000001;
                    end
                end
                dim_pkg::DYN_RAMP2: begin
                    if (onoff_stb_i && onoff_val_i) begin
                        // retrigger restarts hold and final ramp from hold value
                        load = 1'b1;
                        load_lvl = dyn_hold_i;
                        target_next = dyn_hold_i;
                        hold_cnt_next = 24'h000000;
                        dyn_next = dim_pkg::DYN_HOLD;
                    end else if (at_target) begin
                        on_next = (dyn_off_i != dim_pkg::LVL_OFF);
                        dyn_next = dim_pkg::DYN_DONE;
                    end
                end
            endcase
        end else begin
            dyn_next = dim_pkg::DYN_IDLE;
            if (onoff_stb_i) begin
                period_next = onoff_rate;
                if (onoff_val_i) begin
                    target_next = on_clamped;
                    on_next = 1'b1;
                end else begin
                    target_next = dim_pkg::LVL_OFF;
                    on_next = 1'b0;
                end
            end else if (set_stb_i && (on_reg || set_turns_on_i)) begin
                target_next = set_clamped;
                period_next = set_period_i;
                on_next = 1'b1;
            end else if (rel_stb_i) begin
                period_next = rel_period_i;
                if (rel_stop_i) begin
                    target_next = ramp_level;
                end else if (rel_up_i && (on_reg || dim_on_ok_i)) begin
                    target_next = eff_max;
                    on_next = 1'b1;
                    if (!on_reg) begin
                        load = 1'b1;
                        load_lvl = eff_min;
                    end
                end else if (!rel_up_i && on_reg) begin
                    target_next = dim_off_ok_i ? dim_pkg::LVL_OFF : eff_min;
                end
            end else if (on_reg && !rel_stb_i && ramp_level == dim_pkg::LVL_OFF
                    && target_reg == dim_pkg::LVL_OFF) begin
                on_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dyn_reg <= dim_pkg::DYN_IDLE;
            target_reg <= dim_pkg::LVL_OFF;
            period_reg <= dim_pkg::PERIOD_ZERO;
            on_reg <= 1'b0;
            hold_cnt_reg <= 24'h000000;
        end else begin
            dyn_reg <= dyn_next;
            target_reg <= target_next;
            period_reg <= period_next;
            on_reg <= on_next;
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    ramp_gen u_ramp (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick_reg),
        .load_i(load),
        .load_lvl_i(load_lvl),
        .target_i(target_next),
        .period_i(period_next),
        .level_o(ramp_level),
        .at_target_o(at_target)
    );

    // ==========================================================
    // outputs
    logic [7:0] level_reg, level_next;
    logic is_on_reg, dyn_busy_reg;

    always_comb begin
        level_next = ramp_level;
        // burn-in forces a binary output outside dynamic mode, overriding limits and ramps
        if (burn_in_i && !dyn_mode_i) begin
            level_next = on_reg ? dim_pkg::LVL_FULL : dim_pkg::LVL_OFF;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_reg <= 8'h00;
            is_on_reg <= 1'b0;
            dyn_busy_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
            is_on_reg <= on_reg;
            dyn_busy_reg <= (dyn_reg != dim_pkg::DYN_IDLE) && (dyn_reg != dim_pkg::DYN_DONE);
        end
    end

    assign level_o = level_reg;
    assign is_on_o = is_on_reg;
    assign dyn_busy_o = dyn_busy_reg;
endmodule
`default_nettype wire

// ===== test/ballast_model.sv
// behavioural ballast that follows the brightness the channel commands
`timescale 1ns/1ps
`default_nettype none
module ballast_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] level_i,
    output logic [7:0] lamp_o
);
    // ==========================================================
    // lamp state
    logic [7:0] lamp_reg;
    logic [7:0] lamp_next;
    // the lamp lags one cycle, as a real power stage does
    always_comb begin
        lamp_next = level_i;
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lamp_reg <= 8'h00;
        end else begin
            lamp_reg <= lamp_next;
        end
    end
    assign lamp_o = lamp_reg;
endmodule
`default_nettype wire

// ===== test/dim_channel_checker.sv
// concurrent checks on the dimming channel ports
`timescale 1ns/1ps
`default_nettype none
module dim_channel_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic dyn_mode_i,
    input wire logic burn_in_i,
    input wire logic [7:0] on_level_i,
    input wire logic [7:0] min_level_i,
    input wire logic [7:0] max_level_i,
    input wire logic dim_on_ok_i,
    input wire logic set_turns_on_i,
    input wire logic onoff_const_i,
    input wire logic [23:0] onoff_period_i,
    input wire logic [23:0] set_period_i,
    input wire logic [23:0] dyn_ramp1_period_i,
    input wire logic [23:0] dyn_ramp2_period_i,
    input wire logic [7:0] dyn_start_i,
    input wire logic [7:0] dyn_off_i,
    input wire logic onoff_stb_i,
    input wire logic onoff_val_i,
    input wire logic set_stb_i,
    input wire logic [7:0] set_val_i,
    input wire logic rel_stb_i,
    input wire logic rel_up_i,
    input wire logic [7:0] level_o,
    input wire logic is_on_o,
    input wire logic dyn_busy_o
);
    // ==========================================================
    // helpers
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire quiet = !(onoff_stb_i || set_stb_i || rel_stb_i);
    wire norm = !dyn_mode_i && !burn_in_i;
    wire lim_ok = min_level_i <= max_level_i;
    // only immediate (zero-period) changes are timed exactly; ramps are left to the bench
    wire on_imm = norm && onoff_stb_i && onoff_val_i && onoff_period_i == 24'h000000
        && !onoff_const_i;
    property p_reset_out;
        $rose(rst_n_i) |-> level_o == 8'h00 && !is_on_o && !dyn_busy_o;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
    property p_on_level;
        on_imm && lim_ok && on_level_i >= min_level_i && on_level_i <= max_level_i ##1 quiet
            |=> level_o == $past(on_level_i, 2) && is_on_o;
    endproperty
    a_on_level: assert property (p_on_level) else $error("switch-on level wrong");
    property p_on_clamp;
        on_imm && lim_ok && on_level_i > max_level_i ##1 quiet |=> level_o == max_level_i;
    endproperty
    a_on_clamp: assert property (p_on_clamp) else $error("switch-on not clamped");
    property p_min_over;
        on_imm && !lim_ok ##1 quiet |=> level_o == max_level_i;
    endproperty
    a_min_over: assert property (p_min_over) else $error("crossed limits wrong");
    property p_set_low;
        norm && set_stb_i && !onoff_stb_i && (is_on_o || set_turns_on_i) && lim_ok
            && set_period_i == 24'h000000 && set_val_i < min_level_i ##1 quiet
            |=> level_o == min_level_i;
    endproperty
    a_set_low: assert property (p_set_low) else $error("low set value not raised");
    property p_set_refused;
        norm && set_stb_i && !onoff_stb_i && !is_on_o && level_o == 8'h00 && !set_turns_on_i
            ##1 quiet |=> !is_on_o && level_o == 8'h00;
    endproperty
    a_set_refused: assert property (p_set_refused) else $error("set turned channel on");
    property p_rel_refused;
        norm && rel_stb_i && rel_up_i && !onoff_stb_i && !set_stb_i && !is_on_o
            && !dim_on_ok_i ##1 quiet |=> !is_on_o;
    endproperty
    a_rel_refused: assert property (p_rel_refused) else $error("dimming turned on");
    property p_burn;
        (burn_in_i && !dyn_mode_i)[*3] |-> level_o == 8'h00 || level_o == 8'hff;
    endproperty
    a_burn: assert property (p_burn) else $error("burn-in level not full or off");
    property p_dyn_start;
        dyn_mode_i && onoff_stb_i && onoff_val_i && !dyn_busy_o
            && dyn_ramp1_period_i != 24'h000000 ##1 quiet
            |=> dyn_busy_o && level_o == $past(dyn_start_i, 2);
    endproperty
    a_dyn_start: assert property (p_dyn_start) else $error("dynamic start wrong");
    property p_dyn_off;
        dyn_mode_i && dyn_busy_o && onoff_stb_i && !onoff_val_i
            && dyn_ramp2_period_i == 24'h000000 |-> ##[2:4] level_o == dyn_off_i;
    endproperty
    a_dyn_off: assert property (p_dyn_off) else $error("dynamic off late");
    property p_dyn_ignore;
        dyn_mode_i && !dyn_busy_o && !onoff_stb_i && (set_stb_i || rel_stb_i) ##1 quiet
            |=> $stable(level_o);
    endproperty
    a_dyn_ignore: assert property (p_dyn_ignore) else $error("dynamic took set");
endmodule
bind dim_channel dim_channel_checker chk (.*);
`default_nettype wire

// ===== test/test_dim_channel.sv
// self-checking bench for the dimming channel
`timescale 1ns/1ps
`default_nettype none
module test_dim_channel;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic dyn_mode_i = 1'b0, burn_in_i = 1'b0, dim_on_ok_i = 1'b0, dim_off_ok_i = 1'b0;
    logic set_turns_on_i = 1'b0, onoff_const_i = 1'b0, onoff_stb_i = 1'b0;
    logic onoff_val_i = 1'b0, set_stb_i = 1'b0, rel_stb_i = 1'b0, rel_up_i = 1'b0;
    logic rel_stop_i = 1'b0;
    logic [7:0] on_level_i = 8'h80, min_level_i = 8'h20, max_level_i = 8'hc0;
    logic [7:0] dyn_start_i = 8'h40, dyn_hold_i = 8'h44, dyn_off_i = 8'h10, set_val_i = 8'h00;
    logic [23:0] onoff_period_i = 24'h000000, set_period_i = 24'h000000;
    logic [23:0] rel_period_i = 24'h000000, dyn_ramp1_period_i = 24'h0000ff;
    logic [23:0] dyn_hold_ticks_i = 24'h00000a, dyn_ramp2_period_i = 24'h000000;
    wire logic [7:0] level_o;
    wire logic is_on_o, dyn_busy_o;
    int err_count = 0, samples_checked = 0, cycles = 0;
    logic [8:0] exp_q[$];
    event probe_ev;
    dim_channel dut (.*);
    ballast_model lamp (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .level_i(level_o), .lamp_o());
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // tasks
    task automatic end_of_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("[ERR] %0t on/level %h expected %h", $time, seen, want);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // the monitor compares once the launching edge has settled
    task automatic expect_out(input logic on, input logic [7:0] lvl);
        exp_q.push_back({on, lvl});
        -> probe_ev;
        cyc(1);
    endtask
    // kind 0 on/off, 1 set, 2 relative; level 2 edges after the strobe
    task automatic pulse(input int k, input logic v, input logic [7:0] d);
        onoff_val_i = v;
        rel_up_i = v;
        set_val_i = d;
        onoff_stb_i = (k == 0);
        set_stb_i = (k == 1);
        rel_stb_i = (k == 2);
        cyc(1);
        onoff_stb_i = 1'b0;
        set_stb_i = 1'b0;
        rel_stb_i = 1'b0;
        cyc(2);
    endtask
    always @(probe_ev) begin
        chk({is_on_o, level_o}, exp_q.pop_front());
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            end_of_test();
        end
    end
    // ==========================================================
    // scenarios
    initial begin
        void'($urandom(32'h2424));
        cyc(4);
        rst_n_i = 1'b1;
        cyc(2);
        pulse(1, 1'b0, 8'h50);
        expect_out(1'b0, 8'h00);
        pulse(2, 1'b1, 8'h00);
        expect_out(1'b0, 8'h00);
        pulse(0, 1'b1, 8'h00);
        expect_out(1'b1, 8'h80);
        pulse(1, 1'b0, 8'($urandom_range(31, 0)));
        expect_out(1'b1, 8'h20);
        pulse(1, 1'b0, 8'($urandom_range(255, 193)));
        expect_out(1'b1, 8'hc0);
        pulse(0, 1'b1, 8'h00);
        expect_out(1'b1, 8'h80);
        on_level_i = 8'hf0;
        pulse(0, 1'b1, 8'h00);
        expect_out(1'b1, 8'hc0);
        pulse(0, 1'b0, 8'h00);
        expect_out(1'b0, 8'h00);
        min_level_i = 8'hd0;
        max_level_i = 8'h30;
        on_level_i = 8'h10;
        pulse(0, 1'b1, 8'h00);
        expect_out(1'b1, 8'h30);
        pulse(1, 1'b0, 8'hf0);
        expect_out(1'b1, 8'h30);
        min_level_i = 8'h20;
        max_level_i = 8'hc0;
        on_level_i = 8'h80;
        pulse(0, 1'b0, 8'h00);
        set_turns_on_i = 1'b1;
        pulse(1, 1'b0, 8'h60);
        expect_out(1'b1, 8'h60);
        pulse(0, 1'b0, 8'h00);
        dim_on_ok_i = 1'b1;
        pulse(2, 1'b1, 8'h00);
        expect_out(1'b1, 8'hc0);
        pulse(2, 1'b0, 8'h00);
        expect_out(1'b1, 8'h20);
        dim_off_ok_i = 1'b1;
        pulse(2, 1'b0, 8'h00);
        // the on flag drops only once the ramp has reached off, one edge later
        cyc(1);
        expect_out(1'b0, 8'h00);
        burn_in_i = 1'b1;
        pulse(0, 1'b1, 8'h00);
        expect_out(1'b1, 8'hff);
        pulse(0, 1'b0, 8'h00);
        expect_out(1'b0, 8'h00);
        burn_in_i = 1'b0;
        // one step per tick: slow enough to see both ends of the ramp
        min_level_i = 8'h00;
        on_level_i = 8'h03;
        onoff_period_i = 24'h0000ff;
        pulse(0, 1'b1, 8'h00);
        expect_out(1'b1, 8'h00);
        cyc(8100);
        expect_out(1'b1, 8'h03);
        onoff_const_i = 1'b1;
        pulse(0, 1'b0, 8'h00);
        expect_out(1'b0, 8'h00);
        onoff_const_i = 1'b0;
        onoff_period_i = 24'h000000;
        pulse(0, 1'b1, 8'h00);
        set_period_i = 24'h0000ff;
        pulse(1, 1'b0, 8'h06);
        expect_out(1'b1, 8'h03);
        cyc(8100);
        expect_out(1'b1, 8'h06);
        // relative dimming down at its own slow rate: six steps take six ticks
        rel_period_i = 24'h0000ff;
        pulse(2, 1'b0, 8'h00);
        expect_out(1'b1, 8'h06);
        cyc(14100);
        expect_out(1'b0, 8'h00);
        pulse(0, 1'b0, 8'h00);
        dyn_mode_i = 1'b1;
        cyc(2);
        pulse(1, 1'b0, 8'h90);
        expect_out(1'b0, 8'h00);
        pulse(0, 1'b1, 8'h00);
        expect_out(1'b1, 8'h40);
        chk({8'h00, dyn_busy_o}, 9'h001);
        cyc(10000);
        expect_out(1'b1, 8'h44);
        chk({8'h00, dyn_busy_o}, 9'h001);
        // let the hold time run out on its own; final ramp is immediate
        cyc(24000);
        expect_out(1'b1, 8'h10);
        chk({8'h00, dyn_busy_o}, 9'h000);
        pulse(0, 1'b1, 8'h00);
        expect_out(1'b1, 8'h40);
        pulse(0, 1'b0, 8'h00);
        expect_out(1'b1, 8'h10);
        chk({8'h00, dyn_busy_o}, 9'h000);
        end_of_test();
    end
endmodule
`default_nettype wire
